// [src/fba_access.sv]
`timescale 1ns/1ps
module fba_access (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output      logic        hreadyout,
  output      logic        hresp,
  output      logic [31:0] hrdata,
  // Security status
  output      logic        locked_mode,
  output      logic        privilege_restricted_flag
);
  typedef enum logic [1:0] {
    SQ_IDLE,
    SQ_LOAD,
    SQ_STORE
  } fba_seq_e;

  ////////////////////////////////////////////////////////////////
  // State
  fba_pkg::fba_level_e level_r;
  fba_seq_e            seq_r;
  logic [7:0]          class_r;
  logic [7:0]          segment_r;
  logic [7:0]          mode_r;
  logic [15:0]         key_u1_r;
  logic [15:0]         key_u0_r;
  logic [15:0]         key_f1_r;
  logic [15:0]         key_f0_r;
  logic [15:0]         prev_word_r;
  logic                prev_valid_r;
  logic                ckerr_r;
  logic                loaded_r;
  logic                info_loaded_r;
  logic [4:0]          base_r;
  logic [4:0]          cnt_r;
  logic                ld_v_r;
  logic [4:0]          ld_idx_r;
  logic [7:0]          buf_r [fba_pkg::SEG_BYTES];
  logic                dph_r;
  logic                dwrite_r;
  logic [7:0]          daddr_r;
  logic                hreadyout_r;
  logic [31:0]         hrdata_r;
  logic                locked_r;
  logic                priv_r;

  ////////////////////////////////////////////////////////////////
  // Bus decode
  wire        addr_take  = hsel & htrans[1] & hready;
  wire        busy       = (seq_r != SQ_IDLE) | ld_v_r;
  wire        do_access  = dph_r & ~busy;
  wire        do_wr      = do_access & dwrite_r;
  wire        do_rd      = do_access & ~dwrite_r;
  wire        in_window  = daddr_r[7];
  wire [4:0]  win_idx    = daddr_r[6:2];
  wire        wr_class   = do_wr & (daddr_r == fba_pkg::OFS_CLASS);
  wire        wr_segment = do_wr & (daddr_r == fba_pkg::OFS_SEGMENT);
  wire        wr_mode    = do_wr & (daddr_r == fba_pkg::OFS_MODE);
  wire        wr_cksum   = do_wr & (daddr_r == fba_pkg::OFS_CKSUM);
  wire        wr_ctrl    = do_wr & (daddr_r == fba_pkg::OFS_CTRL);
  wire        wr_key_u1  = do_wr & (daddr_r == fba_pkg::OFS_KEY_U1);
  wire        wr_key_u0  = do_wr & (daddr_r == fba_pkg::OFS_KEY_U0);
  wire        wr_key_f1  = do_wr & (daddr_r == fba_pkg::OFS_KEY_F1);
  wire        wr_key_f0  = do_wr & (daddr_r == fba_pkg::OFS_KEY_F0);
  wire        wr_window  = do_wr & in_window;

  ////////////////////////////////////////////////////////////////
  // Access permissions
  wire is_locked = (level_r == fba_pkg::LVL_LOCKED);
  wire is_full   = (level_r == fba_pkg::LVL_FULL);
  // info path when locked or mode set
  wire info_path = is_locked | (mode_r != fba_pkg::MODE_GENERAL);
  wire info_sel  = (hwdata[7:0] == fba_pkg::INFO_SEL_A) | (hwdata[7:0] == fba_pkg::INFO_SEL_B);
  // general path, info block reachable by its class
  wire gen_load  = wr_segment & ~info_path;
  // info block load on select value
  wire info_load = wr_segment & info_path & info_sel;
  wire start_ld  = (seq_r == SQ_IDLE) & (gen_load | info_load);
  // info block class maps to its own segment
  wire       info_cls = (class_r == fba_pkg::INFO_CLASS);
  wire [4:0] new_seg  = {1'b0, class_r[2:0], hwdata[0]};
  wire [4:0] ld_base  = (info_load | info_cls) ? fba_pkg::INFO_SEG : new_seg;
  // locked level never edits the buffer through the window
  wire buf_wr_ok = wr_window & ~is_locked;
  // key storage writable at full level only
  wire key_wr_ok = is_full;

  ////////////////////////////////////////////////////////////////
  // Checksum verification
  logic [8*fba_pkg::SEG_BYTES-1:0] buf_flat;
  logic [7:0]                      expect_ck;

  for (genvar g = 0; g < fba_pkg::SEG_BYTES; g++) begin : g_flat
    assign buf_flat[8*g +: 8] = buf_r[g];
  end

  fba_cksum u_cksum (
    .seg_bytes (buf_flat),
    .expect_ck (expect_ck)
  );

  wire ck_match   = (hwdata[7:0] == expect_ck);
  // commit only on a verified checksum
  wire commit_ok  = wr_cksum & loaded_r & ~is_locked & ck_match;
  wire commit_bad = wr_cksum & loaded_r & ~is_locked & ~ck_match;

  ////////////////////////////////////////////////////////////////
  // Key sequence detection
  // byte-swap the entry before comparing
  wire [15:0] cur_sw   = {hwdata[7:0], hwdata[15:8]};
  wire [15:0] prev_sw  = {prev_word_r[7:0], prev_word_r[15:8]};
  // high word first, low word second
  wire        unseal_m = prev_valid_r & (prev_sw == key_u1_r) & (cur_sw == key_u0_r);
  wire        full_m   = prev_valid_r & (prev_sw == key_f1_r) & (cur_sw == key_f0_r);
  wire        lock_cmd = wr_ctrl & (hwdata[15:0] == fba_pkg::SUB_LOCK);

  ////////////////////////////////////////////////////////////////
  // Non-volatile storage
  logic [fba_pkg::MEM_AW-1:0] mem_wa;
  logic [fba_pkg::MEM_AW-1:0] mem_ra;
  logic [7:0]                 mem_rd;
  wire                        mem_we = (seq_r == SQ_STORE);

  assign mem_wa = {base_r, cnt_r};
  assign mem_ra = {base_r, cnt_r};

  // info block is its own segment in storage
  fba_nvmem u_nvmem (
    .clk     (clk),
    .wr_en   (mem_we),
    .wr_addr (mem_wa),
    .wr_data (buf_r[cnt_r]),
    .rd_addr (mem_ra),
    .rd_data (mem_rd)
  );

  ////////////////////////////////////////////////////////////////
  // Segment sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      seq_r <= SQ_IDLE;
      cnt_r <= 5'h00;
    end else begin
      unique case (seq_r)
        SQ_IDLE: begin
          cnt_r <= 5'h00;
          if (start_ld) begin
            seq_r <= SQ_LOAD;
          end else if (commit_ok) begin
            seq_r <= SQ_STORE;
          end
        end
        SQ_LOAD, SQ_STORE: begin
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == 5'h1f) begin
            seq_r <= SQ_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ld_v_r   <= 1'b0;
      ld_idx_r <= 5'h00;
    end else begin
      ld_v_r   <= (seq_r == SQ_LOAD);
      ld_idx_r <= cnt_r;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      base_r        <= 5'h00;
      loaded_r      <= 1'b0;
      info_loaded_r <= 1'b0;
    end else if (start_ld) begin
      base_r        <= ld_base;
      loaded_r      <= 1'b1;
      info_loaded_r <= info_load;
    end else if (do_wr & info_path != info_loaded_r & wr_mode) begin
      loaded_r      <= 1'b0;
    end
  end

  // Segment buffer, filled by the loader or by window writes
  for (genvar g = 0; g < fba_pkg::SEG_BYTES; g++) begin : g_buf
    always_ff @(posedge clk) begin
      if (reset) begin
        buf_r[g] <= 8'h00;
      end else if (ld_v_r & (ld_idx_r == 5'(g))) begin
        buf_r[g] <= mem_rd;
      end else if (buf_wr_ok & (win_idx == 5'(g))) begin
        buf_r[g] <= hwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Selection registers
  always_ff @(posedge clk) begin
    if (reset) begin
      class_r   <= fba_pkg::RST_CLASS;
      segment_r <= fba_pkg::RST_SEGMENT;
      mode_r    <= fba_pkg::RST_MODE;
    end else begin
      if (wr_class & ~is_locked) begin
        class_r <= hwdata[7:0];
      end
      if (wr_segment) begin
        segment_r <= hwdata[7:0];
      end
      if (wr_mode & ~is_locked) begin
        mode_r <= hwdata[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ckerr_r <= 1'b0;
    end else if (commit_bad) begin
      ckerr_r <= 1'b1;
    end else if (commit_ok | start_ld) begin
      ckerr_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Stored transition keys
  always_ff @(posedge clk) begin
    if (reset) begin
      key_u1_r <= fba_pkg::RST_KEY_U1;
      key_u0_r <= fba_pkg::RST_KEY_U0;
      key_f1_r <= fba_pkg::RST_KEY_F1;
      key_f0_r <= fba_pkg::RST_KEY_F0;
    end else begin
      if (wr_key_u1 & key_wr_ok) begin
        key_u1_r <= hwdata[15:0];
      end
      if (wr_key_u0 & key_wr_ok) begin
        key_u0_r <= hwdata[15:0];
      end
      if (wr_key_f1 & key_wr_ok) begin
        key_f1_r <= hwdata[15:0];
      end
      if (wr_key_f0 & key_wr_ok) begin
        key_f0_r <= hwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Security level
  always_ff @(posedge clk) begin
    if (reset) begin
      prev_word_r  <= 16'h0000;
      prev_valid_r <= 1'b0;
    end else if (wr_ctrl) begin
      // Matched pair is consumed so a third word starts afresh
      prev_word_r  <= hwdata[15:0];
      prev_valid_r <= ~(unseal_m | full_m);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      level_r <= fba_pkg::LVL_LOCKED;
    end else if (lock_cmd) begin
      level_r <= fba_pkg::LVL_LOCKED;
    end else if (wr_ctrl & full_m & ~is_locked) begin
      level_r <= fba_pkg::LVL_FULL;
    end else if (wr_ctrl & unseal_m & is_locked) begin
      level_r <= fba_pkg::LVL_OPEN;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      locked_r <= 1'b1;
      priv_r   <= 1'b1;
    end else begin
      locked_r <= (level_r == fba_pkg::LVL_LOCKED);
      // cleared once full key pair accepted
      priv_r   <= (level_r != fba_pkg::LVL_FULL);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read data mux
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (in_window) begin
      rd_mux = {24'h00_0000, buf_r[win_idx]};
    end else begin
      unique case (daddr_r)
        fba_pkg::OFS_CLASS:   rd_mux = {24'h00_0000, class_r};
        fba_pkg::OFS_SEGMENT: rd_mux = {24'h00_0000, segment_r};
        fba_pkg::OFS_MODE:    rd_mux = {24'h00_0000, mode_r};
        fba_pkg::OFS_CKSUM:   rd_mux = {24'h00_0000, expect_ck};
        fba_pkg::OFS_STATUS: begin
          rd_mux[fba_pkg::ST_LOCKED]        = locked_r;
          rd_mux[fba_pkg::ST_PRIV]          = priv_r;
          rd_mux[fba_pkg::ST_BUSY]          = busy;
          rd_mux[fba_pkg::ST_CKERR]         = ckerr_r;
          rd_mux[fba_pkg::ST_LEVEL +: 2]    = level_r;
        end
        fba_pkg::OFS_KEY_U1:  rd_mux = {16'h0000, key_wr_ok ? key_u1_r : 16'h0000};
        fba_pkg::OFS_KEY_U0:  rd_mux = {16'h0000, key_wr_ok ? key_u0_r : 16'h0000};
        fba_pkg::OFS_KEY_F1:  rd_mux = {16'h0000, key_wr_ok ? key_f1_r : 16'h0000};
        fba_pkg::OFS_KEY_F0:  rd_mux = {16'h0000, key_wr_ok ? key_f0_r : 16'h0000};
        default:              rd_mux = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // AHB-Lite handshake: one wait state, more while the sequencer runs
  always_ff @(posedge clk) begin
    if (reset) begin
      dph_r       <= 1'b0;
      dwrite_r    <= 1'b0;
      daddr_r     <= 8'h00;
      hreadyout_r <= 1'b1;
      hrdata_r    <= 32'h0000_0000;
    end else if (addr_take) begin
      dph_r       <= 1'b1;
      dwrite_r    <= hwrite;
      daddr_r     <= haddr[7:0];
      hreadyout_r <= 1'b0;
    end else if (do_access) begin
      dph_r       <= 1'b0;
      hreadyout_r <= 1'b1;
      if (do_rd) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  assign hreadyout                 = hreadyout_r;
  assign hresp                     = 1'b0;
  assign hrdata                    = hrdata_r;
  assign locked_mode               = locked_r;
  assign privilege_restricted_flag = priv_r;
endmodule

// [src/fba_pkg.sv]
package fba_pkg;
  localparam int SEG_BYTES = 32;
  localparam int SEG_AW    = 5;
  localparam int MEM_AW    = 10;
  localparam int MEM_DEPTH = 17 * SEG_BYTES;
  // Register byte offsets
  localparam logic [7:0] OFS_CLASS   = 8'h00;
  localparam logic [7:0] OFS_SEGMENT = 8'h04;
  localparam logic [7:0] OFS_MODE    = 8'h08;
  localparam logic [7:0] OFS_CKSUM   = 8'h0c;
  localparam logic [7:0] OFS_CTRL    = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  localparam logic [7:0] OFS_KEY_U1  = 8'h20;
  localparam logic [7:0] OFS_KEY_U0  = 8'h24;
  localparam logic [7:0] OFS_KEY_F1  = 8'h28;
  localparam logic [7:0] OFS_KEY_F0  = 8'h2c;
  localparam logic [7:0] OFS_WINDOW  = 8'h80;
  // Status bit positions
  localparam int ST_LOCKED = 0;
  localparam int ST_PRIV   = 1;
  localparam int ST_BUSY   = 2;
  localparam int ST_CKERR  = 3;
  localparam int ST_LEVEL  = 4;
  // Mode, segment and subcommand values
  localparam logic [7:0]  MODE_GENERAL = 8'h00;
  localparam logic [7:0]  INFO_SEL_A   = 8'h01;
  localparam logic [7:0]  INFO_SEL_B   = 8'h02;
  localparam logic [4:0]  INFO_SEG     = 5'h10;
  localparam logic [7:0]  INFO_CLASS   = 8'h39;
  localparam logic [15:0] SUB_LOCK     = 16'h0020;
  // Reset values
  localparam logic [7:0]  RST_CLASS   = 8'h00;
  localparam logic [7:0]  RST_SEGMENT = 8'h00;
  localparam logic [7:0]  RST_MODE    = 8'h00;
  localparam logic [15:0] RST_KEY_U1  = 16'h1234;
  localparam logic [15:0] RST_KEY_U0  = 16'h5678;
  localparam logic [15:0] RST_KEY_F1  = 16'hffff;
  localparam logic [15:0] RST_KEY_F0  = 16'hffff;
  typedef enum logic [1:0] {
    LVL_LOCKED,
    LVL_OPEN,
    LVL_FULL
  } fba_level_e;
endpackage

// [src/fba_nvmem.sv]
`timescale 1ns/1ps
module fba_nvmem (
  // Clock
  input  wire logic                       clk,
  // Write port
  input  wire logic                       wr_en,
  input  wire logic [fba_pkg::MEM_AW-1:0] wr_addr,
  input  wire logic [7:0]                 wr_data,
  // Read port, one cycle latency
  input  wire logic [fba_pkg::MEM_AW-1:0] rd_addr,
  output      logic [7:0]                 rd_data
);
  logic [7:0] mem [fba_pkg::MEM_DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// [src/fba_cksum.sv]
`timescale 1ns/1ps
module fba_cksum (
  // Buffered segment, byte i in bits 8i+7..8i
  input  wire logic [8*fba_pkg::SEG_BYTES-1:0] seg_bytes,
  // Expected checksum
  output      logic [7:0]                      expect_ck
);
  logic [7:0] sum;

  always_comb begin
    sum = 8'h00;
    for (int i = 0; i < fba_pkg::SEG_BYTES; i++) begin
      sum = sum + seg_bytes[8*i +: 8];
    end
    expect_ck = ~sum;
  end
endmodule

// [testbench/fba_access_chk.sv]
`timescale 1ns/1ps
module fba_access_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Status
  input wire logic        locked_mode,
  input wire logic        privilege_restricted_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////
  logic       take;
  logic       pend_r;
  logic [7:0] since_r;
  assign take = hsel && htrans[1] && hready;
  // Cycles since the last completed control write, saturating
  always_ff @(posedge clk) begin
    if (reset) begin
      pend_r  <= 1'b0;
      since_r <= 8'hff;
    end else begin
      if (take) pend_r <= hwrite && (haddr[7:0] == fba_pkg::OFS_CTRL);
      else if (hreadyout) pend_r <= 1'b0;
      if (pend_r && hreadyout) since_r <= 8'h00;
      else if (since_r != 8'hff) since_r <= since_r + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////
  sequence s_take;
    take;
  endsequence
  sequence s_wait;
    !hreadyout ##[1:60] hreadyout;
  endsequence
  a_ready_bound: assert property (s_take |=> s_wait)
    else $error("transfer not answered in time");
  a_reset_state: assert property (disable iff (1'b0) reset |=> hreadyout && locked_mode && privilege_restricted_flag)
    else $error("reset state wrong");
  a_levels_order: assert property (!privilege_restricted_flag |-> !locked_mode)
    else $error("full level while locked");
  a_full_from_open: assert property ($fell(privilege_restricted_flag) |-> !$past(locked_mode))
    else $error("full level entered from locked");
  a_unlock_cause: assert property ($fell(locked_mode) |-> since_r <= 8'h04)
    else $error("unlock without control write");
  a_priv_cause: assert property ($fell(privilege_restricted_flag) |-> since_r <= 8'h04)
    else $error("full level without control write");
  a_lock_cause: assert property ($rose(locked_mode) |-> since_r <= 8'h04)
    else $error("lock without control write");
  a_rdata_hold: assert property ($changed(hrdata) |-> $rose(hreadyout))
    else $error("read data moved outside completion");
  a_resp_okay: assert property (!hresp)
    else $error("error response on the bus");
endmodule

bind fba_access fba_access_chk u_chk (
  .clk                       (clk),
  .reset                     (reset),
  .hsel                      (hsel),
  .haddr                     (haddr),
  .htrans                    (htrans),
  .hwrite                    (hwrite),
  .hwdata                    (hwdata),
  .hready                    (hready),
  .hreadyout                 (hreadyout),
  .hresp                     (hresp),
  .hrdata                    (hrdata),
  .locked_mode               (locked_mode),
  .privilege_restricted_flag (privilege_restricted_flag)
);

// [testbench/fba_host.sv]
`timescale 1ns/1ps
module fba_host (
  // Clock
  input wire logic         clk,
  // Bus master side
  output     logic         hsel,
  output     logic [31:0]  haddr,
  output     logic [1:0]   htrans,
  output     logic         hwrite,
  output     logic [2:0]   hsize,
  output     logic [31:0]  hwdata,
  input wire logic         hreadyout,
  input wire logic [31:0]  hrdata
);
  int         hangs;
  logic [7:0] byte_sum;
  initial begin
    hsel     = 1'b0;
    haddr    = 32'h00000000;
    htrans   = 2'b00;
    hwrite   = 1'b0;
    hsize    = 3'b010;
    hwdata   = 32'h00000000;
    hangs    = 0;
    byte_sum = 8'h00;
  end
  ////////////////////////////////////////////////////////////////
  // Released lines show the inverse so stale values never match
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'b010;
    @(posedge clk);
    while (!hreadyout && n < 300) begin
      @(posedge clk);
      n++;
    end
    hsel   <= 1'b0;
    htrans <= 2'b00;
    haddr  <= ~{24'h000000, a};
    hwdata <= d;
    @(posedge clk);
    while (!hreadyout && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (n >= 300) hangs++;
    q = hrdata;
    hwdata <= ~d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h00000000, q);
  endtask
  task automatic pick(input logic [7:0] cls, input logic [7:0] seg);
    wr(fba_pkg::OFS_CLASS, {24'h000000, cls});
    wr(fba_pkg::OFS_SEGMENT, {24'h000000, seg});
  endtask
  // consecutive swapped words, high word first
  // callers use keys unlike any subcommand code
  task automatic keys(input logic [15:0] k1, input logic [15:0] k0);
    wr(fba_pkg::OFS_CTRL, {16'h0000, k1[7:0], k1[15:8]});
    wr(fba_pkg::OFS_CTRL, {16'h0000, k0[7:0], k0[15:8]});
  endtask
  task automatic fill(input logic [7:0] base);
    byte_sum = 8'h00;
    for (int i = 0; i < 32; i++) begin
      wr(fba_pkg::OFS_WINDOW + 8'(4 * i), {24'h000000, base + 8'(7 * i)});
      byte_sum = byte_sum + base + 8'(7 * i);
    end
  endtask
  // complement of the low sum byte
  task automatic commit(input logic good);
    wr(fba_pkg::OFS_CKSUM, {24'h000000, good ? ~byte_sum : byte_sum});
  endtask
endmodule

// [testbench/fba_access_tb.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin err_total++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module fba_access_tb;
  logic        clk;
  logic        reset;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        locked_mode;
  logic        privilege_restricted_flag;
  logic [31:0] q;
  int          err_total;
  int          samples_checked;
  fba_host host (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hreadyout(hreadyout), .hrdata(hrdata));
  fba_access uut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .locked_mode(locked_mode), .privilege_restricted_flag(privilege_restricted_flag));
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    close_out();
  end
  task automatic close_out();
    err_total += host.hangs;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Flags lag the level by one clock
  task automatic chk_flags(input logic lk, input logic pv, input fba_pkg::fba_level_e lv);
    repeat (2) @(posedge clk);
    `CHK("locked", lk, locked_mode)
    `CHK("restricted", pv, privilege_restricted_flag)
    host.rd(fba_pkg::OFS_STATUS, q);
    `CHK("level", lv, q[fba_pkg::ST_LEVEL +: 2])
  endtask
  task automatic chk_buf(input logic [7:0] base);
    for (int i = 0; i < 32; i++) begin
      host.rd(fba_pkg::OFS_WINDOW + 8'(4 * i), q);
      `CHK("window", base + 8'(7 * i), q[7:0])
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_unlock();
    chk_flags(1'b1, 1'b1, fba_pkg::LVL_LOCKED);
    host.keys(fba_pkg::RST_KEY_U0, fba_pkg::RST_KEY_U1);
    chk_flags(1'b1, 1'b1, fba_pkg::LVL_LOCKED);
    host.keys(fba_pkg::RST_KEY_U1, fba_pkg::RST_KEY_U0);
    chk_flags(1'b0, 1'b1, fba_pkg::LVL_OPEN);
  endtask
  task automatic t_keys();
    host.wr(fba_pkg::OFS_KEY_U1, 32'h00004321);
    host.keys(fba_pkg::RST_KEY_F1, fba_pkg::RST_KEY_F0);
    chk_flags(1'b0, 1'b0, fba_pkg::LVL_FULL);
    host.rd(fba_pkg::OFS_KEY_U1, q);
    `CHK("key kept", fba_pkg::RST_KEY_U1, q[15:0])
    host.wr(fba_pkg::OFS_KEY_U1, 32'h00004321);
    host.rd(fba_pkg::OFS_KEY_U1, q);
    `CHK("key set", 16'h4321, q[15:0])
  endtask
  task automatic t_general();
    host.wr(fba_pkg::OFS_MODE, 32'h00000000);
    host.pick(8'h03, 8'h00);
    host.fill(8'h11);
    host.commit(1'b1);
    host.pick(8'h03, 8'h01);
    host.fill(8'h5a);
    host.commit(1'b1);
    host.rd(fba_pkg::OFS_STATUS, q);
    `CHK("ck error", 1'b0, q[fba_pkg::ST_CKERR])
    host.pick(8'h03, 8'h00);
    chk_buf(8'h11);
    host.fill(8'h33);
    host.commit(1'b0);
    host.rd(fba_pkg::OFS_STATUS, q);
    `CHK("ck error", 1'b1, q[fba_pkg::ST_CKERR])
    chk_flags(1'b0, 1'b0, fba_pkg::LVL_FULL);
    host.pick(8'h03, 8'h00);
    chk_buf(8'h11);
    host.pick(8'h03, 8'h01);
    chk_buf(8'h5a);
  endtask
  task automatic t_info();
    host.wr(fba_pkg::OFS_MODE, 32'h00000001);
    host.wr(fba_pkg::OFS_SEGMENT, {24'h000000, fba_pkg::INFO_SEL_B});
    host.fill(8'h77);
    host.commit(1'b1);
    host.wr(fba_pkg::OFS_SEGMENT, {24'h000000, fba_pkg::INFO_SEL_A});
    chk_buf(8'h77);
    host.wr(fba_pkg::OFS_MODE, 32'h00000000);
    host.pick(fba_pkg::INFO_CLASS, 8'h00);
    chk_buf(8'h77);
    host.wr(fba_pkg::OFS_CTRL, {16'h0000, fba_pkg::SUB_LOCK});
    chk_flags(1'b1, 1'b1, fba_pkg::LVL_LOCKED);
    host.fill(8'h99);
    chk_buf(8'h77);
    host.commit(1'b1);
    host.rd(fba_pkg::OFS_STATUS, q);
    `CHK("ck error", 1'b0, q[fba_pkg::ST_CKERR])
    host.wr(fba_pkg::OFS_SEGMENT, {24'h000000, fba_pkg::INFO_SEL_B});
    chk_buf(8'h77);
  endtask
  task automatic t_new_key();
    host.keys(fba_pkg::RST_KEY_U1, fba_pkg::RST_KEY_U0);
    chk_flags(1'b1, 1'b1, fba_pkg::LVL_LOCKED);
    host.keys(16'h4321, fba_pkg::RST_KEY_U0);
    chk_flags(1'b0, 1'b1, fba_pkg::LVL_OPEN);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    err_total       = 0;
    samples_checked = 0;
    reset           = 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_unlock();
    t_keys();
    t_general();
    t_info();
    t_new_key();
    close_out();
  end
endmodule
